/* File: src/pp_cfg_regs.sv */
// parallel port configuration registers behind an AXI4-Lite slave
// assumes port datapath logic on CORE_CLK; the acknowledge pin arrives asynchronously
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module pp_cfg_regs
   import pp_cfg_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic [DATA_W/8-1:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [DATA_W-1:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic ACK_N,
   input wire logic PORT_IRQ_REQ,
   input wire logic ECP_FIFO_ACTIVE,
   input wire logic EPP_TIMEOUT_SET,
   input wire logic EPP_STATUS_RD,
   output logic PP_IRQ_O,
   output logic PP_IRQ_OE,
   output cfgb_t EXT_PORT_CONFIG_B,
   output port_mode_t PORT_MODE,
   output mode_flags_t MODE_FLAGS,
   output logic [THR_W-1:0] ECP_THRESHOLD,
   output logic TMO_CLR_ON_READ,
   output logic EPP_TIMEOUT_FLAG,
   output logic INT_IRQ
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      cfgb_t cfgb;
      logic [7:0] mode;
      logic tsel;
      logic [INT_W-1:0] istat;
      logic [INT_W-1:0] imask;
      logic tmo;
      logic ack_s1;
      logic ack_s2;
      logic ack_s3;
      logic rd_prev;
      logic req_prev;
      logic [PULSE_CW-1:0] pcnt;
      logic irq_o;
      logic irq_oe;
      logic int_irq;
      mode_flags_t flags;
      logic awv;
      logic [ADDR_W-1:0] awaddr;
      logic wv;
      logic [DATA_W-1:0] wdata;
      logic wstrb0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } st_t;

   st_t s_q;
   st_t s_d;

   function automatic mode_flags_t decode(input port_mode_t m);
      mode_flags_t f;
      f.printer = (m == PM_PRINTER);
      f.spp = (m == PM_SPP) || (m == PM_EPP19) || (m == PM_EPP17);
      f.epp = (m == PM_EPP19) || (m == PM_EPP17) || (m == PM_ECP_EPP19) || (m == PM_ECP_EPP17);
      f.epp17 = (m == PM_EPP17) || (m == PM_ECP_EPP17);
      f.ecp = (m == PM_ECP) || (m == PM_ECP_EPP19) || (m == PM_ECP_EPP17);
      return f;
   endfunction

   function automatic logic idx_hit(input logic [IDX_W-1:0] i);
      return (i == IDX_IRQ_SEL) || (i == IDX_DMA_SEL) || (i == IDX_MODE) || (i == IDX_MODE2) ||
             (i == IDX_INT_STAT) || (i == IDX_INT_MASK) || (i == IDX_EPP_STAT);
   endfunction

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] ar_idx;
   logic wr_do;
   logic wr_hit;
   logic wr_byte;
   logic ar_hit;
   port_mode_t mode_c;
   mode_flags_t flags_c;
   logic plain;
   logic pulse_mode;
   logic fifo_lvl;
   logic ack_fall;
   logic req_rise;
   logic rd_fall;
   logic pulse_ev;
   logic tmo_wr_clr;
   logic tmo_clr;
   logic [INT_W-1:0] istat_clr;
   logic [INT_W-1:0] ev;

   assign wr_idx = s_q.awaddr[IDX_LSB +: IDX_W];
   assign ar_idx = ARADDR[IDX_LSB +: IDX_W];
   // response waits until the previous one is taken
   assign wr_do = s_q.awv && s_q.wv && !s_q.bvalid;
   assign wr_hit = (s_q.awaddr[ADDR_W-1:IDX_LSB+IDX_W] == '0) && idx_hit(wr_idx);
   assign wr_byte = wr_do && wr_hit && s_q.wstrb0;
   assign ar_hit = (ARADDR[ADDR_W-1:IDX_LSB+IDX_W] == '0) && idx_hit(ar_idx);

   assign mode_c = port_mode_t'(s_q.mode[MODE_LSB +: MODE_W]);
   assign plain = (mode_c == PM_PRINTER) || (mode_c == PM_SPP);
   assign pulse_mode = !plain && s_q.mode[TYPE_BIT];
   assign flags_c = decode(mode_c);
   assign fifo_lvl = !plain && flags_c.ecp && ECP_FIFO_ACTIVE;
   assign ack_fall = s_q.ack_s3 && !s_q.ack_s2;
   assign req_rise = PORT_IRQ_REQ && !s_q.req_prev;
   assign rd_fall = s_q.rd_prev && !EPP_STATUS_RD;
   assign pulse_ev = pulse_mode && (fifo_lvl ? req_rise : ack_fall);

   assign tmo_wr_clr = wr_byte && (wr_idx == IDX_EPP_STAT) && s_q.wdata[TMO_BIT] && !s_q.tsel;
   assign tmo_clr = s_q.tsel ? rd_fall : tmo_wr_clr;
   assign istat_clr = (wr_byte && (wr_idx == IDX_INT_STAT)) ? s_q.wdata[INT_W-1:0] : '0;
   always_comb begin
      ev = '0;
      ev[INT_TMO] = EPP_TIMEOUT_SET;
      ev[INT_ACK] = ack_fall;
      ev[INT_REQ] = req_rise;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // acknowledge pin through two flops, third only for edge detection
      s_d.ack_s1 = ACK_N;
      s_d.ack_s2 = s_q.ack_s1;
      s_d.ack_s3 = s_q.ack_s2;
      s_d.rd_prev = EPP_STATUS_RD;
      s_d.req_prev = PORT_IRQ_REQ;

      // write channel: address and data taken in either order
      if (AWVALID && s_q.awready) begin
         s_d.awv = 1'b1;
         s_d.awaddr = AWADDR;
         s_d.awready = 1'b0;
      end
      if (WVALID && s_q.wready) begin
         s_d.wv = 1'b1;
         s_d.wdata = WDATA;
         s_d.wstrb0 = WSTRB[0];
         s_d.wready = 1'b0;
      end
      if (s_q.bvalid && BREADY) begin
         s_d.bvalid = 1'b0;
      end
      if (wr_do) begin
         s_d.awv = 1'b0;
         s_d.wv = 1'b0;
         s_d.awready = 1'b1;
         s_d.wready = 1'b1;
         s_d.bvalid = 1'b1;
         s_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      // registers live in byte lane zero; other lanes are ignored
      if (wr_byte) begin
         case (wr_idx)
            IDX_IRQ_SEL: s_d.cfgb.irq = s_q.wdata[IRQ_FLD_W-1:0];
            IDX_DMA_SEL: s_d.cfgb.dma = s_q.wdata[DMA_FLD_W-1:0];
            IDX_MODE: s_d.mode = s_q.wdata[7:0];
            IDX_MODE2: s_d.tsel = s_q.wdata[TSEL_BIT];
            IDX_INT_MASK: s_d.imask = s_q.wdata[INT_W-1:0];
            default: s_d.tsel = s_q.tsel;
         endcase
      end

      // sticky events, a set in the clearing cycle survives
      s_d.istat = (s_q.istat & ~istat_clr) | ev;
      s_d.int_irq = |(s_d.istat & s_d.imask);
      s_d.tmo = EPP_TIMEOUT_SET || (s_q.tmo && !tmo_clr);

      // read channel, one outstanding read
      if (s_q.rvalid && RREADY) begin
         s_d.rvalid = 1'b0;
         s_d.arready = 1'b1;
      end
      if (ARVALID && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.arready = 1'b0;
         s_d.rresp = ar_hit ? RESP_OKAY : RESP_SLVERR;
         s_d.rdata = '0;
         if (ar_hit) begin
            case (ar_idx)
               IDX_IRQ_SEL: s_d.rdata = DATA_W'(s_q.cfgb.irq);
               IDX_DMA_SEL: s_d.rdata = DATA_W'(s_q.cfgb.dma);
               IDX_MODE: s_d.rdata = DATA_W'(s_q.mode);
               IDX_MODE2: s_d.rdata = DATA_W'(s_q.tsel) << TSEL_BIT;
               IDX_INT_STAT: s_d.rdata = DATA_W'(s_q.istat);
               IDX_INT_MASK: s_d.rdata = DATA_W'(s_q.imask);
               default: s_d.rdata = DATA_W'(s_q.tmo) << TMO_BIT;
            endcase
         end
      end

      s_d.flags = decode(port_mode_t'(s_d.mode[MODE_LSB +: MODE_W]));

      // port interrupt pin
      s_d.pcnt = (s_q.pcnt != '0) ? s_q.pcnt - PULSE_CW'(1) : '0;
      if (!pulse_mode) begin
         // type bit has no say in printer and spp modes
         s_d.pcnt = '0;
         s_d.irq_oe = 1'b1;
         s_d.irq_o = fifo_lvl ? PORT_IRQ_REQ : s_q.ack_s2;
      end else if (pulse_ev) begin
         s_d.pcnt = PULSE_LOAD;
         s_d.irq_oe = 1'b1;
         s_d.irq_o = 1'b0;
      end else if (s_q.pcnt != '0) begin
         s_d.irq_oe = 1'b1;
         s_d.irq_o = 1'b0;
      end else begin
         // released, the shared line floats high
         s_d.irq_oe = 1'b0;
         s_d.irq_o = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         s_q <= '0;
         s_q.cfgb.irq <= RST_IRQ_SEL;
         s_q.cfgb.dma <= RST_DMA_SEL;
         s_q.mode <= RST_MODE;
         s_q.tsel <= RST_TSEL;
         s_q.flags.printer <= 1'b1;
         s_q.ack_s1 <= 1'b1;
         s_q.ack_s2 <= 1'b1;
         s_q.ack_s3 <= 1'b1;
         s_q.irq_o <= 1'b1;
         s_q.irq_oe <= 1'b1;
         s_q.awready <= 1'b1;
         s_q.wready <= 1'b1;
         s_q.arready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign AWREADY = s_q.awready;
   assign WREADY = s_q.wready;
   assign BVALID = s_q.bvalid;
   assign BRESP = s_q.bresp;
   assign ARREADY = s_q.arready;
   assign RVALID = s_q.rvalid;
   assign RDATA = s_q.rdata;
   assign RRESP = s_q.rresp;
   assign PP_IRQ_O = s_q.irq_o;
   assign PP_IRQ_OE = s_q.irq_oe;
   assign EXT_PORT_CONFIG_B = s_q.cfgb;
   assign PORT_MODE = port_mode_t'(s_q.mode[MODE_LSB +: MODE_W]);
   assign MODE_FLAGS = s_q.flags;
   assign ECP_THRESHOLD = s_q.mode[THR_LSB +: THR_W];
   assign TMO_CLR_ON_READ = s_q.tsel;
   assign EPP_TIMEOUT_FLAG = s_q.tmo;
   assign INT_IRQ = s_q.int_irq;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);

   AST_CFGB_IRQ_SRC: assert property (
      !$stable(EXT_PORT_CONFIG_B.irq) |-> $past(wr_byte && wr_idx == IDX_IRQ_SEL))
      else $error("irq mirror changed without a write");
   AST_CFGB_DMA_SRC: assert property (
      !$stable(EXT_PORT_CONFIG_B.dma) |-> $past(wr_byte && wr_idx == IDX_DMA_SEL))
      else $error("dma mirror changed without a write");
   AST_MODE_DECODE: assert property (
      MODE_FLAGS.printer == (PORT_MODE == PM_PRINTER) &&
      MODE_FLAGS.ecp == (PORT_MODE inside {PM_ECP, PM_ECP_EPP19, PM_ECP_EPP17}) &&
      MODE_FLAGS.epp17 == (PORT_MODE inside {PM_EPP17, PM_ECP_EPP17}))
      else $error("mode flags disagree with mode code");
   AST_THR_WRITE: assert property (
      $past(wr_byte && wr_idx == IDX_MODE) |-> ECP_THRESHOLD == $past(s_q.wdata[THR_LSB +: THR_W]))
      else $error("threshold not loaded from bits six to three");
   AST_TYPE_IGNORED: assert property (
      $past(plain) |-> PP_IRQ_OE && PP_IRQ_O == $past(s_q.ack_s2))
      else $error("interrupt pin not following acknowledge in plain mode");
   AST_PULSE_LOW: assert property (
      pulse_ev |=> PP_IRQ_OE && !PP_IRQ_O && s_q.pcnt == PULSE_LOAD)
      else $error("pulse did not drive low");
   AST_PULSE_HOLD: assert property (
      s_q.pcnt != '0 |-> PP_IRQ_OE && !PP_IRQ_O)
      else $error("pin released before pulse count ran out");
   AST_PULSE_RELEASE: assert property (
      $past(pulse_mode && !pulse_ev && s_q.pcnt == '0) |-> !PP_IRQ_OE)
      else $error("pin not released after pulse");
   AST_FOLLOW_ACK: assert property (
      $past(!pulse_mode && !fifo_lvl) |-> PP_IRQ_OE && PP_IRQ_O == $past(s_q.ack_s2))
      else $error("interrupt pin not following acknowledge");
   AST_FIFO_LEVEL: assert property (
      $past(!pulse_mode && fifo_lvl) |-> PP_IRQ_OE && PP_IRQ_O == $past(PORT_IRQ_REQ))
      else $error("level interrupt not tracking request");
   AST_TMO_HOLD: assert property (
      $past(!s_q.tsel && s_q.tmo && !tmo_wr_clr) |-> EPP_TIMEOUT_FLAG)
      else $error("timeout flag lost without write of one");
   AST_TMO_READ_CLR: assert property (
      $past(s_q.tsel && rd_fall && !EPP_TIMEOUT_SET) |-> !EPP_TIMEOUT_FLAG)
      else $error("timeout flag not cleared after status read");

   COV_PULSE: cover property (pulse_ev ##1 PP_IRQ_OE ##[1:20] !PP_IRQ_OE);
   COV_READ_CLR: cover property (s_q.tsel && s_q.tmo ##1 rd_fall);
   COV_WRITE: cover property (wr_byte && wr_idx == IDX_MODE);

endmodule
`default_nettype wire

/* File: src/pp_cfg_pkg.sv */
// constants and carrier types for the parallel port configuration register bank
// assumes a 100 MHz core clock and an AXI4-Lite master with 32-bit data
`default_nettype none
package pp_cfg_pkg;

   // ------------------------------------------------------------
   // bus and address layout
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_IRQ_SEL = 8'h70;
   localparam logic [IDX_W-1:0] IDX_DMA_SEL = 8'h74;
   localparam logic [IDX_W-1:0] IDX_MODE = 8'hF0;
   localparam logic [IDX_W-1:0] IDX_MODE2 = 8'hF1;
   localparam logic [IDX_W-1:0] IDX_INT_STAT = 8'h80;
   localparam logic [IDX_W-1:0] IDX_INT_MASK = 8'h81;
   localparam logic [IDX_W-1:0] IDX_EPP_STAT = 8'h82;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int IRQ_FLD_W = 4;
   localparam int DMA_FLD_W = 3;
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 3;
   localparam int THR_LSB = 3;
   localparam int THR_W = 4;
   localparam int TYPE_BIT = 7;
   localparam int TSEL_BIT = 4;
   localparam int TMO_BIT = 0;
   localparam logic [IRQ_FLD_W-1:0] RST_IRQ_SEL = 4'h0;
   localparam logic [DMA_FLD_W-1:0] RST_DMA_SEL = 3'h0;
   localparam logic [7:0] RST_MODE = 8'h3C;
   localparam logic RST_TSEL = 1'b0;

   // sticky event bits
   localparam int INT_TMO = 0;
   localparam int INT_ACK = 1;
   localparam int INT_REQ = 2;
   localparam int INT_W = 3;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int IRQ_PULSE_NS = 100;
   localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CW = $clog2(IRQ_PULSE_CYC + 1);
   localparam logic [PULSE_CW-1:0] PULSE_LOAD = PULSE_CW'(IRQ_PULSE_CYC - 1);

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PM_SPP       = 3'b000,
      PM_EPP19     = 3'b001,
      PM_ECP       = 3'b010,
      PM_ECP_EPP19 = 3'b011,
      PM_PRINTER   = 3'b100,
      PM_EPP17     = 3'b101,
      PM_RSVD      = 3'b110,
      PM_ECP_EPP17 = 3'b111
   } port_mode_t;

   typedef struct packed {
      logic printer;
      logic spp;
      logic epp;
      logic epp17;
      logic ecp;
   } mode_flags_t;

   typedef struct packed {
      logic [IRQ_FLD_W-1:0] irq;
      logic [DMA_FLD_W-1:0] dma;
   } cfgb_t;

endpackage
`default_nettype wire

/* File: tb/parallel_port_config_regs_bench.sv */
// self-checking bench for the parallel port configuration register bank
// assumes pp_cfg_regs and pp_cfg_pkg from src/; bready and rready stay high throughout
`timescale 1ns/10ps
`default_nettype none
module parallel_port_config_regs_bench;
   import pp_cfg_pkg::*;

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] awaddr = '0;
   logic awvalid = 1'b0;
   logic [DATA_W-1:0] wdata = '0;
   logic wvalid = 1'b0;
   logic [3:0] wstrb = 4'hF;
   logic [ADDR_W-1:0] araddr = '0;
   logic arvalid = 1'b0;
   logic ack_n = 1'b1;
   logic port_irq_req = 1'b0;
   logic ecp_fifo_active = 1'b0;
   logic epp_timeout_set = 1'b0;
   logic epp_status_rd = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pp_irq_o, pp_irq_oe, tmo_sel, tmo_flag, int_irq;
   logic [1:0] bresp, rresp, rsp;
   logic [DATA_W-1:0] rdata, rd;
   logic [THR_W-1:0] thr_out, th;
   logic [3:0] iv;
   logic [2:0] dv;
   cfgb_t cfgb;
   port_mode_t mode_out;
   mode_flags_t flags;
   int mismatches = 0;
   int samples_checked = 0;
   int cnt;
   logic [2:0] codes [7] = '{3'b100, 3'b000, 3'b001, 3'b101, 3'b010, 3'b011, 3'b111};

   pp_cfg_regs dut (.CORE_CLK(core_clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(1'b1), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(1'b1), .ACK_N(ack_n), .PORT_IRQ_REQ(port_irq_req),
      .ECP_FIFO_ACTIVE(ecp_fifo_active), .EPP_TIMEOUT_SET(epp_timeout_set), .EPP_STATUS_RD(epp_status_rd),
      .PP_IRQ_O(pp_irq_o), .PP_IRQ_OE(pp_irq_oe), .EXT_PORT_CONFIG_B(cfgb), .PORT_MODE(mode_out),
      .MODE_FLAGS(flags), .ECP_THRESHOLD(thr_out), .TMO_CLR_ON_READ(tmo_sel), .EPP_TIMEOUT_FLAG(tmo_flag),
      .INT_IRQ(int_irq));

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] mode_word(input logic t, input logic [3:0] h, input logic [2:0] m);
      return {24'h0, t, h, m};
   endfunction

   // expected {printer, spp, epp, epp17, ecp} for a mode code
   function automatic logic [4:0] flags_for(input logic [2:0] m);
      logic [4:0] f;
      f[4] = (m == 3'b100);
      f[3] = (m == 3'b000) || (m == 3'b001) || (m == 3'b101);
      f[2] = (m == 3'b001) || (m == 3'b101) || (m == 3'b011) || (m == 3'b111);
      f[1] = (m == 3'b101) || (m == 3'b111);
      f[0] = (m == 3'b010) || (m == 3'b011) || (m == 3'b111);
      return f;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask

   // waits end only on the answer; the watchdog catches a hang
   task automatic axi_write(input logic [IDX_W-1:0] idx, input logic [31:0] d, output logic [1:0] r);
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
   endtask

   task automatic axi_read(input logic [IDX_W-1:0] idx, output logic [31:0] d, output logic [1:0] r);
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask

   task automatic check_defaults();
      axi_read(IDX_IRQ_SEL, rd, rsp);
      check(rd, 32'h0);
      axi_read(IDX_DMA_SEL, rd, rsp);
      check(rd, 32'h0);
      axi_read(IDX_MODE, rd, rsp);
      check(rd, 32'h3C);
      axi_read(IDX_MODE2, rd, rsp);
      check(rd, 32'h0);
      check(32'(mode_out), 32'(PM_PRINTER));
      check(32'(thr_out), 32'h7);
      check(32'(tmo_flag), 32'h0);
   endtask

   // pin must mirror the acknowledge level while driven
   task automatic follow_check();
      ack_n <= 1'b0;
      cyc(6);
      check({30'h0, pp_irq_oe, pp_irq_o}, 32'h2);
      ack_n <= 1'b1;
      cyc(6);
      check({30'h0, pp_irq_oe, pp_irq_o}, 32'h3);
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(81661));
      cyc(10);
      rst <= 1'b0;
      @(posedge core_clk);
      check_defaults();
      for (int i = 0; i < 8; i++) begin
         iv = (i == 0) ? 4'hF : 4'($urandom);
         dv = (i == 0) ? 3'h7 : 3'($urandom);
         axi_write(IDX_IRQ_SEL, {28'h0, iv}, rsp);
         axi_write(IDX_DMA_SEL, {29'h0, dv}, rsp);
         axi_read(IDX_IRQ_SEL, rd, rsp);
         check(rd, {28'h0, iv});
         axi_read(IDX_DMA_SEL, rd, rsp);
         check(rd, {29'h0, dv});
         check(32'(cfgb), {25'h0, iv, dv});
      end
      for (int i = 0; i < 7; i++) begin
         th = 4'($urandom);
         axi_write(IDX_MODE, mode_word(1'b0, th, codes[i]), rsp);
         axi_read(IDX_MODE, rd, rsp);
         check(rd, mode_word(1'b0, th, codes[i]));
         check(32'(mode_out), 32'(codes[i]));
         check(32'(thr_out), 32'(th));
         check(32'(flags.printer), 32'(codes[i] == 3'b100));
         check(32'(flags.ecp), 32'(codes[i][1]));
         check(32'(flags), 32'(flags_for(codes[i])));
      end
      // unmapped place: refused, contents untouched
      axi_write(8'h40, 32'hFFFF_FFFF, rsp);
      check(32'(rsp), 32'(RESP_SLVERR));
      axi_read(8'h40, rd, rsp);
      check({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
      // lane zero not strobed: accepted, nothing stored
      wstrb <= 4'hE;
      axi_write(IDX_IRQ_SEL, {28'h0, ~iv}, rsp);
      wstrb <= 4'hF;
      check(32'(rsp), 32'(RESP_OKAY));
      axi_read(IDX_IRQ_SEL, rd, rsp);
      check(rd, {28'h0, iv});
      axi_write(IDX_MODE, mode_word(1'b1, 4'h7, PM_PRINTER), rsp);
      follow_check();
      axi_write(IDX_MODE, mode_word(1'b1, 4'h7, PM_SPP), rsp);
      follow_check();
      axi_write(IDX_MODE, mode_word(1'b0, 4'h7, PM_EPP19), rsp);
      follow_check();
      axi_write(IDX_MODE, mode_word(1'b0, 4'h7, PM_ECP), rsp);
      follow_check();
      ecp_fifo_active <= 1'b1;
      port_irq_req <= 1'b1;
      cyc(4);
      check({30'h0, pp_irq_oe, pp_irq_o}, 32'h3);
      port_irq_req <= 1'b0;
      cyc(4);
      check({30'h0, pp_irq_oe, pp_irq_o}, 32'h2);
      ecp_fifo_active <= 1'b0;
      // earlier acknowledge edges must not mask the pulse's own event
      axi_write(IDX_INT_STAT, 32'h7, rsp);
      axi_write(IDX_MODE, mode_word(1'b1, 4'h7, PM_EPP19), rsp);
      cyc(4);
      ack_n <= 1'b0;
      cnt = 0;
      do begin
         @(posedge core_clk);
         cnt++;
      end while (!(pp_irq_oe === 1'b1 && pp_irq_o === 1'b0) && cnt < 12);
      cnt = 0;
      while (pp_irq_oe === 1'b1 && pp_irq_o === 1'b0 && cnt < 40) begin
         @(posedge core_clk);
         cnt++;
      end
      check(32'(cnt), 32'(IRQ_PULSE_CYC));
      check(32'(pp_irq_oe), 32'h0);
      ack_n <= 1'b1;
      axi_read(IDX_INT_STAT, rd, rsp);
      check(32'(rd[INT_ACK]), 32'h1);
      axi_write(IDX_INT_STAT, 32'h7, rsp);
      // timeout flag, write-one clear selected
      epp_timeout_set <= 1'b1;
      @(posedge core_clk);
      epp_timeout_set <= 1'b0;
      cyc(2);
      check({30'h0, tmo_flag, int_irq}, 32'h2);
      axi_write(IDX_INT_MASK, 32'h1, rsp);
      cyc(2);
      check(32'(int_irq), 32'h1);
      axi_write(IDX_INT_STAT, 32'h1, rsp);
      cyc(2);
      check(32'(int_irq), 32'h0);
      epp_status_rd <= 1'b1;
      cyc(2);
      epp_status_rd <= 1'b0;
      cyc(2);
      check(32'(tmo_flag), 32'h1);
      axi_write(IDX_EPP_STAT, 32'h1, rsp);
      cyc(1);
      check(32'(tmo_flag), 32'h0);
      // read-trailing-edge clear selected
      axi_write(IDX_MODE2, 32'h10, rsp);
      epp_timeout_set <= 1'b1;
      @(posedge core_clk);
      epp_timeout_set <= 1'b0;
      axi_write(IDX_EPP_STAT, 32'h1, rsp);
      epp_status_rd <= 1'b1;
      cyc(3);
      check({30'h0, tmo_sel, tmo_flag}, 32'h3);
      epp_status_rd <= 1'b0;
      cyc(2);
      check(32'(tmo_flag), 32'h0);
      // fifo mode with pulse type: request rise starts the pulse
      axi_write(IDX_MODE, mode_word(1'b1, 4'h7, PM_ECP), rsp);
      ecp_fifo_active <= 1'b1;
      port_irq_req <= 1'b1;
      cyc(3);
      check({30'h0, pp_irq_oe, pp_irq_o}, 32'h2);
      port_irq_req <= 1'b0;
      ecp_fifo_active <= 1'b0;
      cyc(12);
      check(32'(pp_irq_oe), 32'h0);
      // reset in mid-run restores every default
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      @(posedge core_clk);
      check_defaults();
      end_of_test();
   end

   // run needs a few hundred cycles; far beyond that is a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      end_of_test();
   end
endmodule
`default_nettype wire
